//--- hw/sdiac_core.sv
// video correction and ancillary extraction stage
//
// Notes on behaviour
// - pin high and trs disable low: regenerate timing words from internal timing.
// - inserted timing words are always full 10-bit values.
// - hd/3g only: line crc inserted on both channels when enabled.
// - hd/3g only: line numbers recomputed and inserted on both channels.
// - anc checksums regenerated, only programmed types when filters set, any type while no packet is tracked.
// - sd only: field crcs overwritten when received packet present and enabled.
// - inserted packet has validity bits high; status shows received flags.
// - field error flags updated only while flag update mask low.
// - active picture words 3FC..3FF become 3FB when remap enabled.
// - active picture words 000..003 become 004 when remap enabled.
// - 8-bit preambles always expand to 10 bits; every 3FC word outside remapped active picture becomes 3FF, not only in headers.
// - buffer of 2048 sixteen-bit words in two banks of 1024.
// - packets stored from first flag, up to 1024 words, found anywhere.
// - luma/stream one in low byte, chroma in high byte, zero in sd.
// - all type filters zero extracts all; else only programmed types.
// - two line selects limit extraction; zero selects mean all lines.
// - clearing extraction mask starts at next frame in first bank.
// - rising switch selects second bank; falling switch clears first bank, selects it only if second is full.
// - default luma; chroma-only and both bits select, ignored in sd.
// - delete replaces packets with blanking; pin low stops extract and delete.
// - all correction except 8-bit preamble expansion active only in full processing mode.
// - all feature disable bits low after reset except the extraction mask.
`timescale 1ns/1ps
module sdiac_core
  import sdiac_pkg::*;
(
  input  wire logic        clk,                    // 40 MHz pixel clock
  input  wire logic        rst,                    // synchronous reset, high
  input  wire logic        processing_enable_pin,  // processing enable pin
  input  wire logic        full_mode,              // full standard processing mode
  input  wire logic [1:0]  std_mode,               // 0 sd, 1 hd, 2 3g
  input  wire logic        in_valid,               // video word valid
  input  wire logic [9:0]  in_y,                   // luma / stream one word
  input  wire logic [9:0]  in_c,                   // chroma / stream two word
  input  wire logic        tg_trs,                 // timing gen: trs word slot
  input  wire logic [9:0]  tg_trs_word,            // timing gen: regenerated trs word
  input  wire logic        tg_active,              // timing gen: active picture
  input  wire logic        tg_sof,                 // timing gen: start of frame
  input  wire logic [10:0] tg_line,                // timing gen: current line
  input  wire logic        ln_slot,                // line number word slot
  input  wire logic [9:0]  ln_y,                   // recomputed luma line word
  input  wire logic [9:0]  ln_c,                   // recomputed chroma line word
  input  wire logic        crc_slot,               // line crc word slot
  input  wire logic [9:0]  crc_y,                  // computed luma crc word
  input  wire logic [9:0]  crc_c,                  // computed chroma crc word
  input  wire logic        cs_slot,                // anc checksum word slot
  input  wire logic [9:0]  cs_y,                   // computed luma checksum
  input  wire logic [9:0]  cs_c,                   // computed chroma checksum
  input  wire logic        edh_present,            // received error packet seen
  input  wire logic        edh_crc_slot,           // field crc word slot
  input  wire logic [9:0]  edh_crc_word,           // computed field crc word
  input  wire logic        edh_flag_slot,          // error flag word slot
  input  wire logic [9:0]  edh_flag_word,          // updated flag word, v bits set
  input  wire logic        edh_sum_slot,           // edh packet checksum slot
  input  wire logic [9:0]  edh_sum_word,           // recomputed edh checksum
  input  wire logic        rx_active_picture_valid, // received ap validity flag
  input  wire logic        rx_full_field_valid,    // received ff validity flag
  input  wire logic        locked,                 // receiver lock indicator
  input  wire logic [13:0] avs_address,            // avalon byte address
  input  wire logic        avs_read,               // avalon read
  input  wire logic        avs_write,              // avalon write
  input  wire logic [31:0] avs_writedata,          // avalon write data
  input  wire logic [3:0]  avs_byteenable,         // avalon byte enables
  output logic [31:0]      avs_readdata,           // avalon read data
  output logic             avs_waitrequest,        // avalon wait request
  output logic [1:0]       avs_response,           // avalon response
  output logic             out_valid,              // output word valid
  output logic [9:0]       out_y,                  // corrected luma word
  output logic [9:0]       out_c,                  // corrected chroma word
  output logic             luma_anc_present_flag,  // luma anc being extracted
  output logic             chroma_anc_present_flag // chroma anc being extracted
);
  ////////////////////////////////////////////////////////////////////////////
  // state
  typedef struct packed {
    logic [DIS_W-1:0]    dis;       // processing_feature_disable_reg
    logic [CTRL_W-1:0]   ctl;       // processing_control_reg
    logic [10:0]         line_a;
    logic [10:0]         line_b;
    logic [NTYPES*16-1:0] types;
    logic                armed;     // extraction running (after frame start)
    logic                bank;      // bank being written
    logic                full_a;
    logic                full_b;
    logic [AW:0]         wptr;
    logic                clr;       // clearing first bank
    logic [AW-1:0]       clr_ptr;
    sdiac_ex_t           ex;
    logic [7:0]          did;
    logic                keep;
    logic                del;
    logic [9:0]          p1_y;      // preamble history
    logic [9:0]          p2_y;
    logic [9:0]          p3_y;
    logic [9:0]          p1_c;
    logic [9:0]          p2_c;
    logic [9:0]          p3_c;
    logic                ov;
    logic [9:0]          oy;
    logic [9:0]          oc;
    logic                fy;
    logic                fc;
    logic                ack;
    logic [31:0]         rdata;
    logic [1:0]          resp;
    logic                rd_buf;
  } sdiac_st_t;
  sdiac_st_t st_r, st_nxt;

  logic [15:0] bank_a [BANK_WORDS];
  logic [15:0] bank_b [BANK_WORDS];
  logic [15:0] ram_q;
  logic        we;
  logic [AW-1:0] wa;
  logic [15:0] wd;

  // preamble words; 8-bit ones is 3FC, other 8-bit forms are unsupported
  function automatic logic is_ones(input logic [9:0] w);
    is_ones = (w == V_ONES) || (w == V_HI_ILL);
  endfunction : is_ones
  function automatic logic is_zero(input logic [9:0] w);
    is_zero = (w == V_ZERO);
  endfunction : is_zero
  // clamp illegal active picture codes
  function automatic logic [9:0] remap(input logic [9:0] w);
    if (w >= V_HI_ILL) remap = V_MAXLEGAL;
    else if (w <= V_LO_ILL) remap = V_MINLEGAL;
    else remap = w;
  endfunction : remap

  ////////////////////////////////////////////////////////////////////////////
  // next state
  logic       pen, is_sd, hdv, pre_y, pre_c, sel_y, sel_c, line_ok, tmatch;
  logic [9:0] y, c;
  logic [7:0] dsel;
  always_comb begin
    st_nxt = st_r;
    pen   = processing_enable_pin && full_mode;
    is_sd = (std_mode == STD_SD);
    hdv   = (std_mode == STD_HD) || (std_mode == STD_3G);
    we = 1'b0;
    wa = st_r.wptr[AW-1:0];
    wd = 16'h0000;
    // flag 000 3FF 3FF seen on history, always active
    pre_y = is_zero(st_r.p2_y) && is_ones(st_r.p1_y) && is_ones(in_y);
    pre_c = is_zero(st_r.p2_c) && is_ones(st_r.p1_c) && is_ones(in_c);
    y = in_y;
    c = in_c;
    if (is_ones(y)) y = V_ONES;
    if (is_ones(c)) c = V_ONES;
    // illegal code remap in active picture
    if (pen && !st_r.dis[D_REMAP] && tg_active && st_r.ex == EX_IDLE) begin
      y = remap(in_y);
      c = remap(in_c);
    end
    // timing words come from the timing generator, full 10 bits
    if (pen && !st_r.dis[D_TRS] && tg_trs) begin
      y = tg_trs_word;
      c = tg_trs_word;
    end
    if (pen && hdv && !st_r.dis[D_LNUM] && ln_slot) begin
      y = ln_y;
      c = ln_c;
    end
    if (pen && hdv && !st_r.dis[D_CRC] && crc_slot) begin
      y = crc_y;
      c = crc_c;
    end
    // field crcs, sd only with a received packet
    if (pen && is_sd && edh_present && !st_r.dis[D_EDH]) begin
      if (edh_crc_slot) y = edh_crc_word;
      if (edh_sum_slot) y = edh_sum_word;
      // flags only with update mask low
      if (edh_flag_slot && !st_r.dis[D_EFLAG]) y = edh_flag_word;
    end
    // type filter match, all zero means all types
    dsel = (st_r.ex == EX_ADF) ? in_y[7:0] : st_r.did;
    tmatch = (st_r.types == '0);
    for (int i = 0; i < NTYPES; i++) begin
      if (st_r.types[i*16 +: 16] != 16'h0000 && st_r.types[i*16+8 +: 8] == dsel)
        tmatch = 1'b1;
    end
    if (pen && !st_r.dis[D_CSUM] && cs_slot && (tmatch || st_r.ex == EX_IDLE)) begin
      y = cs_y;
      c = is_sd ? c : cs_c;
    end
    // delete matched packets with blanking, gaps left in place
    if (pen && st_r.del && st_r.ex != EX_IDLE) begin
      y = BLANK_Y;
      c = is_sd ? BLANK_Y : BLANK_C;
    end
    sel_c = !is_sd && (st_r.ctl[C_BOTH] || st_r.ctl[C_CHROMA]);
    sel_y = is_sd || st_r.ctl[C_BOTH] || !st_r.ctl[C_CHROMA];
    line_ok = (st_r.line_a == 11'h000 && st_r.line_b == 11'h000) ||
              (st_r.line_a != 11'h000 && st_r.line_a == tg_line) ||
              (st_r.line_b != 11'h000 && st_r.line_b == tg_line);
    if (in_valid) begin
      st_nxt.p3_y = st_r.p2_y;
      st_nxt.p2_y = st_r.p1_y;
      st_nxt.p1_y = in_y;
      st_nxt.p3_c = st_r.p2_c;
      st_nxt.p2_c = st_r.p1_c;
      st_nxt.p1_c = in_c;
      // packet tracking anywhere in the stream
      case (st_r.ex)
        EX_IDLE: if (pre_y || (pre_c && sel_c)) st_nxt.ex = EX_ADF;
        // decided on the identifier while the flag words sit in the history
        EX_ADF: begin
          st_nxt.did  = in_y[7:0];
          st_nxt.keep = tmatch && line_ok && st_r.armed && pen && !st_r.dis[D_EXT];
          st_nxt.del  = tmatch && st_r.ctl[C_DELETE];
          st_nxt.ex   = EX_HDR;
        end
        EX_HDR: st_nxt.ex = EX_BODY;
        EX_BODY: if (pre_y || tg_trs || st_r.wptr[AW] ) begin
          st_nxt.ex = EX_IDLE;
          st_nxt.keep = 1'b0;
          st_nxt.del = 1'b0;
        end
        default: st_nxt.ex = EX_IDLE;
      endcase
      // store three words behind the input so a packet opens with its flag
      if ((st_r.ex == EX_ADF ? st_nxt.keep : st_r.keep) && !st_r.wptr[AW]) begin
        we = 1'b1;
        wd = {(sel_c && !is_sd) ? st_r.p3_c[7:0] : 8'h00, sel_y ? st_r.p3_y[7:0] : 8'h00};
        st_nxt.wptr = st_r.wptr + 11'd1;
        if (st_r.wptr[AW-1:0] == 10'h3FF) begin
          if (st_r.bank) st_nxt.full_b = 1'b1;
          else st_nxt.full_a = 1'b1;
        end
      end
    end
    st_nxt.fy = st_r.keep && sel_y;
    st_nxt.fc = st_r.keep && sel_c;
    // extraction starts at next frame when unmasked
    if (st_r.dis[D_EXT] || !pen) st_nxt.armed = 1'b0;
    else if (tg_sof) st_nxt.armed = 1'b1;
    st_nxt.ov = in_valid;
    st_nxt.oy = y;
    st_nxt.oc = c;
    // first bank clear runs one word per cycle
    if (st_r.clr) begin
      st_nxt.clr_ptr = st_r.clr_ptr + 10'd1;
      if (st_r.clr_ptr == 10'h3FF) st_nxt.clr = 1'b0;
    end
    ////////////////////////////////////////////////////////////////////////
    // avalon slave: one wait cycle, then answer
    st_nxt.ack = 1'b0;
    st_nxt.resp = 2'h0;
    if ((avs_read || avs_write) && !st_r.ack) begin
      st_nxt.ack = 1'b1;
      st_nxt.rdata = 32'h0000_0000;
      // buffer words at consecutive word addresses, selected bank
      if (avs_address >= BUF_BASE) begin
        if (avs_write) st_nxt.resp = BUS_ERR;
      end else if (avs_write) begin
        case (avs_address)
          REG_DISABLE: if (avs_byteenable[0]) st_nxt.dis = avs_writedata[DIS_W-1:0];
          REG_CTRL: if (avs_byteenable[0]) begin
            st_nxt.ctl = avs_writedata[CTRL_W-1:0];
            // rising edge selects second bank; falling edge wipes first bank, selects it only if second is full
            if (avs_writedata[C_SWITCH] && !st_r.ctl[C_SWITCH]) begin
              st_nxt.bank = 1'b1;
              st_nxt.full_b = 1'b0;
              st_nxt.wptr = 11'd0;
            end else if (!avs_writedata[C_SWITCH] && st_r.ctl[C_SWITCH]) begin
              st_nxt.clr = 1'b1;
              st_nxt.clr_ptr = 10'h000;
              st_nxt.full_a = 1'b0;
              if (st_r.full_b) begin
                st_nxt.bank = 1'b0;
                st_nxt.wptr = 11'd0;
              end
            end
          end
          REG_LINE_A: st_nxt.line_a = avs_writedata[10:0];
          REG_LINE_B: st_nxt.line_b = avs_writedata[10:0];
          REG_STATUS: ;
          default: begin
            if (avs_address >= REG_TYPE0 && avs_address < REG_STATUS)
              st_nxt.types[3'(avs_address[4:2] - 3'd4)*16 +: 16] = avs_writedata[15:0];
            else st_nxt.resp = BUS_ERR;
          end
        endcase
      end else begin
        case (avs_address)
          REG_DISABLE: st_nxt.rdata = {24'h0, st_r.dis};
          REG_CTRL:    st_nxt.rdata = {28'h0, st_r.ctl};
          REG_LINE_A:  st_nxt.rdata = {21'h0, st_r.line_a};
          REG_LINE_B:  st_nxt.rdata = {21'h0, st_r.line_b};
          // status shows received validity flags, bank full flags, bank, armed and write pointer
          REG_STATUS:  st_nxt.rdata = {15'h0, st_r.wptr, st_r.armed, st_r.bank,
                                      st_r.full_b, st_r.full_a, rx_full_field_valid,
                                      rx_active_picture_valid};
          default: begin
            if (avs_address >= REG_TYPE0 && avs_address < REG_STATUS)
              st_nxt.rdata = {16'h0, st_r.types[3'(avs_address[4:2] - 3'd4)*16 +: 16]};
            else st_nxt.resp = BUS_ERR;
          end
        endcase
      end
    end
    if (st_r.clr) we = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // buffer banks; the host reads the first bank while switch is set, else the second
  always_ff @(posedge clk) begin
    if (st_r.clr) bank_a[st_r.clr_ptr] <= 16'h0000;
    else if (we && !st_r.bank) bank_a[wa] <= wd;
    if (we && st_r.bank) bank_b[wa] <= wd;
    // host reads meaningful only while locked
    ram_q <= st_r.ctl[C_SWITCH] ? bank_a[avs_address[11:2]] : bank_b[avs_address[11:2]];
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st_r <= '0;
      st_r.dis <= DIS_RESET;
      st_r.ctl <= CTRL_RESET;
      st_r.ex  <= EX_IDLE;
    end else begin
      st_r <= st_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs
  assign avs_waitrequest = (avs_read || avs_write) && !st_r.ack;
  assign avs_readdata    = (avs_address >= BUF_BASE) ? {16'h0, ram_q} : st_r.rdata;
  assign avs_response    = st_r.resp;
  assign out_valid       = st_r.ov;
  assign out_y           = st_r.oy;
  assign out_c           = st_r.oc;
  assign luma_anc_present_flag   = st_r.fy;
  assign chroma_anc_present_flag = st_r.fc;
endmodule : sdiac_core

//--- include/sdiac_pkg.sv
// constants and register map for the video correction and ancillary extraction stage
package sdiac_pkg;
  // register byte offsets
  localparam logic [13:0] REG_DISABLE  = 14'h0000;
  localparam logic [13:0] REG_CTRL     = 14'h0004;
  localparam logic [13:0] REG_LINE_A   = 14'h0008;
  localparam logic [13:0] REG_LINE_B   = 14'h000C;
  localparam logic [13:0] REG_TYPE0    = 14'h0010;  // five type filters
  localparam logic [13:0] REG_STATUS   = 14'h0024;
  localparam logic [13:0] BUF_BASE     = 14'h1000;  // 1024 words, four bytes apart
  // feature disable bit positions
  localparam int D_TRS   = 0;
  localparam int D_CRC   = 1;
  localparam int D_LNUM  = 2;
  localparam int D_CSUM  = 3;
  localparam int D_EDH   = 4;
  localparam int D_REMAP = 5;
  localparam int D_EFLAG = 6;
  localparam int D_EXT   = 7;
  localparam int DIS_W   = 8;
  // control bit positions
  localparam int C_SWITCH = 0;
  localparam int C_CHROMA = 1;
  localparam int C_BOTH   = 2;
  localparam int C_DELETE = 3;
  localparam int CTRL_W   = 4;
  localparam logic [DIS_W-1:0]  DIS_RESET  = 8'h80;  // extraction starts masked
  localparam logic [CTRL_W-1:0] CTRL_RESET = 4'h0;
  // buffer geometry
  localparam int BANK_WORDS = 1024;
  localparam int AW         = 10;
  localparam int NTYPES     = 5;
  // video code values
  localparam logic [9:0] V_MAXLEGAL = 10'h3FB;
  localparam logic [9:0] V_MINLEGAL = 10'h004;
  localparam logic [9:0] V_HI_ILL   = 10'h3FC;
  localparam logic [9:0] V_LO_ILL   = 10'h003;
  localparam logic [9:0] V_ONES     = 10'h3FF;
  localparam logic [9:0] V_ZERO     = 10'h000;
  localparam logic [9:0] BLANK_Y    = 10'h040;
  localparam logic [9:0] BLANK_C    = 10'h200;
  localparam logic [1:0] STD_SD     = 2'h0;
  localparam logic [1:0] STD_HD     = 2'h1;
  localparam logic [1:0] STD_3G     = 2'h2;
  localparam logic [1:0] BUS_ERR    = 2'h2;
  // extractor states
  typedef enum logic [3:0] {
    EX_IDLE = 4'h1, EX_ADF = 4'h2, EX_HDR = 4'h4, EX_BODY = 4'h8
  } sdiac_ex_t;
endpackage : sdiac_pkg

//--- sim/sdiac_sink.sv
// downstream consumer model: bank-switch and read permissions, packet activity
`timescale 1ns/1ps
module sdiac_sink (
  input  wire logic clk,                     // pixel clock
  input  wire logic rst,                     // synchronous reset, high
  input  wire logic locked,                  // receiver lock indicator
  input  wire logic luma_anc_present_flag,   // luma packet being stored
  input  wire logic chroma_anc_present_flag, // chroma packet being stored
  output logic      switch_ok,               // bank switch may change now
  output logic      read_ok,                 // buffer may be read now
  output int        anc_cycles               // cycles with a packet stored
);
  //////////////////////////////////////////////////////////////////////
  // flip the bank only between packets, never mid-store
  assign switch_ok = !luma_anc_present_flag && !chroma_anc_present_flag;
  // reads on unlocked video would return stale packets
  assign read_ok = locked;
  // packet activity seen downstream, cleared by reset
  always_ff @(posedge clk) begin
    if (rst) begin
      anc_cycles <= 0;
    end else if (!switch_ok) begin
      anc_cycles <= anc_cycles + 1;
    end
  end
endmodule : sdiac_sink

//--- sim/sdiac_core_monitor.sv
// port-level checker for the correction stage
`timescale 1ns/1ps
module sdiac_core_monitor
  import sdiac_pkg::*;
(
  input wire logic        clk,                   // pixel clock
  input wire logic        rst,                   // synchronous reset
  input wire logic        processing_enable_pin, // processing enable
  input wire logic        full_mode,             // full processing mode
  input wire logic [1:0]  std_mode,              // video standard
  input wire logic        in_valid,              // input word valid
  input wire logic [9:0]  in_y,                  // input luma word
  input wire logic        tg_trs,                // timing word slot
  input wire logic [9:0]  tg_trs_word,           // regenerated timing word
  input wire logic        tg_active,             // active picture
  input wire logic        ln_slot,               // line number slot
  input wire logic [9:0]  ln_y,                  // line number word
  input wire logic        crc_slot,              // line crc slot
  input wire logic [9:0]  crc_y,                 // line crc word
  input wire logic [13:0] avs_address,           // bus address
  input wire logic        avs_read,              // bus read
  input wire logic        avs_write,             // bus write
  input wire logic [31:0] avs_writedata,         // bus write data
  input wire logic        avs_waitrequest,       // bus wait
  input wire logic        out_valid,             // output valid
  input wire logic [9:0]  out_y                  // output luma word
);
  //////////////////////////////////////////////////////////////////////
  logic [DIS_W-1:0] dis_r;
  logic             en;
  logic             act;
  // disable register shadow
  always_ff @(posedge clk) begin
    if (rst) begin
      dis_r <= DIS_RESET;
    end else if (avs_write && !avs_waitrequest && avs_address == REG_DISABLE) begin
      dis_r <= avs_writedata[DIS_W-1:0];
    end
  end
  // qualifiers shared by the insertion checks
  assign en = processing_enable_pin && full_mode && in_valid;
  assign act = en && tg_active && !tg_trs && !dis_r[D_REMAP];
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_req;
    (avs_read || avs_write) && avs_waitrequest;
  endsequence
  //////////////////////////////////////////////////////////////////////
  a_bus_answer: assert property (s_req |=> !avs_waitrequest)
    else $error("bus request not answered next cycle");
  a_word_latency: assert property (in_valid |=> out_valid)
    else $error("output word missing one cycle after input");
  a_trs_regen: assert property (en && tg_trs && !dis_r[D_TRS] |=> out_y == $past(tg_trs_word))
    else $error("timing word not regenerated");
  a_crc_insert: assert property (en && crc_slot && std_mode != STD_SD && !dis_r[D_CRC]
    |=> out_y == $past(crc_y)) else $error("line crc not inserted");
  a_lnum_insert: assert property (en && ln_slot && std_mode != STD_SD && !dis_r[D_LNUM]
    |=> out_y == $past(ln_y)) else $error("line number not inserted");
  a_remap_high: assert property (act && in_y >= V_HI_ILL |=> out_y == V_MAXLEGAL)
    else $error("high illegal code not remapped");
  a_remap_low: assert property (act && in_y <= V_LO_ILL |=> out_y == V_MINLEGAL)
    else $error("low illegal code not remapped");
  a_pin_pass: assert property (!processing_enable_pin && in_valid && in_y != V_HI_ILL
    |=> out_y == $past(in_y)) else $error("word altered with processing off");
endmodule : sdiac_core_monitor
bind sdiac_core sdiac_core_monitor sdiac_core_monitor_inst (
  .clk, .rst, .processing_enable_pin, .full_mode, .std_mode, .in_valid, .in_y, .tg_trs,
  .tg_trs_word, .tg_active, .ln_slot, .ln_y, .crc_slot, .crc_y, .avs_address, .avs_read,
  .avs_write, .avs_writedata, .avs_waitrequest, .out_valid, .out_y);

//--- sim/sdiac_core_bench.sv
// self-checking bench for the correction and extraction stage
`timescale 1ns/1ps
module sdiac_core_bench;
  import sdiac_pkg::*;
  localparam logic [4:0] M_HD = 5'h0D, M_SD = 5'h0C, M_SDE = 5'h1C, M_OFF = 5'h05, M_BYP = 5'h09;
  logic        clk = 0, rst = 1, processing_enable_pin = 1, full_mode = 1, edh_present = 0;
  logic [1:0]  std_mode = STD_HD, rsp, avs_response;
  logic        in_valid = 0, tg_trs = 0, tg_active = 0, tg_sof = 0, ln_slot = 0, crc_slot = 0;
  logic        cs_slot = 0, edh_crc_slot = 0, edh_flag_slot = 0, edh_sum_slot = 0, locked = 1;
  logic        rx_active_picture_valid = 0, rx_full_field_valid = 0, avs_read = 0, avs_write = 0;
  logic [9:0]  in_y = 0, in_c = 0, tg_trs_word = 0, ln_y = 0, ln_c = 0, crc_y = 0, crc_c = 0;
  logic [9:0]  cs_y = 0, cs_c = 0, edh_crc_word = 0, edh_flag_word = 0, edh_sum_word = 0;
  logic [9:0]  out_y, out_c;
  logic [9:0]  pk [7] = '{10'h000, 10'h3FF, 10'h3FF, 10'h155, 10'h2AA, 10'h000, 10'h155};
  logic [10:0] tg_line = 0;
  logic [13:0] avs_address = 0;
  logic [31:0] avs_writedata = 0, avs_readdata, rd;
  logic [3:0]  avs_byteenable = 4'hF;
  logic        avs_waitrequest, out_valid, luma_anc_present_flag, chroma_anc_present_flag;
  logic        switch_ok, read_ok;
  int          errors = 0, n_checks = 0, cyc = 0, anc_cycles;
  //////////////////////////////////////////////////////////////////////
  sdiac_core sdiac_core_inst (
    .clk, .rst, .processing_enable_pin, .full_mode, .std_mode, .in_valid, .in_y, .in_c,
    .tg_trs, .tg_trs_word, .tg_active, .tg_sof, .tg_line, .ln_slot, .ln_y, .ln_c,
    .crc_slot, .crc_y, .crc_c, .cs_slot, .cs_y, .cs_c, .edh_present, .edh_crc_slot,
    .edh_crc_word, .edh_flag_slot, .edh_flag_word, .edh_sum_slot, .edh_sum_word,
    .rx_active_picture_valid, .rx_full_field_valid, .locked, .avs_address, .avs_read,
    .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest,
    .avs_response, .out_valid, .out_y, .out_c, .luma_anc_present_flag,
    .chroma_anc_present_flag);
  sdiac_sink sdiac_sink_inst (
    .clk, .rst, .locked, .luma_anc_present_flag, .chroma_anc_present_flag, .switch_ok,
    .read_ok, .anc_cycles);
  //////////////////////////////////////////////////////////////////////
  // clock and hang guard
  always #12.5 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      errors++;
      finish_test();
    end
  end
  task automatic chk32(input logic [31:0] g, e);
    n_checks++;
    if (g !== e) begin
      errors++;
      $display("wrong value at %0t: bus got %h expected %h", $time, g, e);
    end
  endtask : chk32
  task automatic chk10(input logic [9:0] g, e);
    n_checks++;
    if (g !== e) begin
      errors++;
      $display("wrong value at %0t: video got %h expected %h", $time, g, e);
    end
  endtask : chk10
  // one bus cycle; hold the request until waitrequest is seen low
  task automatic bus(input logic wr, input logic [13:0] a, input logic [31:0] d);
    @(posedge clk);
    avs_read <= !wr;
    avs_write <= wr;
    avs_address <= a;
    avs_writedata <= d;
    do @(posedge clk); while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    rsp = avs_response;
    avs_read <= 0;
    avs_write <= 0;
  endtask : bus
  // one video word with slots s and mode m, output checked one cycle on
  task automatic vw(input logic [9:0] y, g, ey, input logic [8:0] s, input logic [4:0] m);
    @(posedge clk);
    in_valid <= 1;
    in_y <= y;
    in_c <= y;
    {edh_present, processing_enable_pin, full_mode, std_mode} <= m;
    {tg_sof, tg_active, edh_sum_slot, edh_flag_slot, edh_crc_slot, cs_slot, crc_slot,
     ln_slot, tg_trs} <= s;
    {tg_trs_word, ln_y, ln_c, crc_y, crc_c, cs_y, cs_c, edh_crc_word, edh_flag_word,
     edh_sum_word} <= {10{g}};
    @(posedge clk);
    in_valid <= 0;
    @(posedge clk);
    #1 chk10(out_y, ey);
  endtask : vw
  task automatic finish_test;
    $display("checks %0d mismatches %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : finish_test
  //////////////////////////////////////////////////////////////////////
  initial begin
    repeat (6) @(posedge clk);
    rst <= 0;
    bus(0, REG_DISABLE, 0);
    chk32(rd, {24'h0, DIS_RESET});
    bus(0, REG_CTRL, 0);
    chk32(rd, 32'h0);
    bus(0, 14'h0030, 0);
    chk32({30'h0, rsp}, {30'h0, BUS_ERR});
    bus(1, BUF_BASE, 32'h1);
    chk32({30'h0, rsp}, {30'h0, BUS_ERR});
    bus(1, REG_LINE_A, 32'h7FF);
    bus(0, REG_LINE_A, 0);
    chk32(rd, 32'h7FF);
    bus(1, REG_LINE_A, 0);
    rx_active_picture_valid <= 1;
    rx_full_field_valid <= 1;
    bus(0, REG_STATUS, 0);
    chk32(rd & 32'h3, 32'h3);
    $display("test registers done");
    bus(1, REG_DISABLE, 0);
    vw(10'h123, 10'h3FF, 10'h3FF, 9'h001, M_HD);
    vw(10'h123, 10'h2A5, 10'h2A5, 9'h002, M_HD);
    vw(10'h123, 10'h1C7, 10'h1C7, 9'h004, M_HD);
    vw(10'h123, 10'h1C7, 10'h123, 9'h004, M_SD);
    for (int i = 0; i < 4; i++) begin
      vw(V_HI_ILL + 10'(i), 10'h0, V_MAXLEGAL, 9'h080, M_HD);
      vw(V_ZERO + 10'(i), 10'h0, V_MINLEGAL, 9'h080, M_HD);
    end
    vw(10'h123, 10'h0F0, 10'h0F0, 9'h010, M_SDE);
    vw(10'h123, 10'h0F0, 10'h123, 9'h010, M_SD);
    vw(10'h123, 10'h0F0, 10'h0F0, 9'h020, M_SDE);
    vw(10'h123, 10'h3FF, 10'h123, 9'h001, M_OFF);
    vw(10'h3FE, 10'h0, 10'h3FE, 9'h080, M_BYP);
    bus(1, REG_DISABLE, 32'h61);
    vw(10'h123, 10'h0F0, 10'h123, 9'h020, M_SDE);
    vw(10'h123, 10'h0F0, 10'h0F0, 9'h040, M_SDE);
    vw(10'h3FE, 10'h0, 10'h3FE, 9'h080, M_HD);
    vw(10'h123, 10'h3FF, 10'h123, 9'h001, M_HD);
    $display("test correction done");
    bus(1, REG_DISABLE, 0);
    bus(1, REG_CTRL, 32'h2);
    vw(10'h040, 10'h0, 10'h040, 9'h100, M_SD);
    for (int i = 0; i < 7; i++) begin
      @(posedge clk);
      in_valid <= 1;
      in_y <= pk[i];
    end
    repeat (3) vw(10'h040, 10'h0, 10'h040, 9'h000, M_SD);
    vw(10'h040, 10'h3FF, 10'h3FF, 9'h001, M_SD);
    chk32({31'h0, anc_cycles > 0}, 32'h1);
    chk32({31'h0, switch_ok}, 32'h1);
    bus(1, REG_CTRL, 32'h3);
    chk32({31'h0, read_ok}, 32'h1);
    for (int i = 0; i < 7; i++) begin
      bus(0, BUF_BASE + 14'(4 * i), 0);
      chk32(rd, {24'h0, pk[i][7:0]});
    end
    $display("test extraction done");
    finish_test();
  end
endmodule : sdiac_core_bench
